//--- core/rc_params.svh
`ifndef RC_PARAMS_SVH
`define RC_PARAMS_SVH
// register byte offsets on the bus
`define RC_REG_CTRL 8'h00
`define RC_REG_STATUS 8'h04
`define RC_REG_DATA 8'h08
`define RC_REG_IRQ_STAT 8'h0C
`define RC_REG_IRQ_CLR 8'h10
`define RC_REG_IRQ_EN 8'h14
`define RC_REG_MATCH_CNT 8'h18
`define RC_REG_MATCH_CMD 8'h1C
// control register fields
`define RC_CTRL_FMT_LSB 0
`define RC_CTRL_MODE_LSB 2
`define RC_CTRL_AF_BIT 4
`define RC_CTRL_COND_BIT 5
`define RC_CTRL_RESET 6'h00
// match command fields
`define RC_MCMD_CHAR_LSB 0
`define RC_MCMD_OFS_LSB 8
`define RC_MCMD_IDX_LSB 20
`define RC_MCMD_CODE_LSB 24
`define RC_MCMD_CODE_WRITE 8'hE7
`define RC_MCMD_CODE_POINT 8'h00
// match store sizing
`define RC_MATCH_TOTAL 3000
`define RC_MATCH_CNT_RESET 4'h1
// interrupt event bits
`define RC_EV_START 0
`define RC_EV_READY 1
`define RC_EV_FAIL 2
`define RC_EV_CMDERR 3
`endif

//--- core/rc_pkg.sv
package rc_pkg;
	// input assembly layouts seen by the controller
	typedef enum logic [1:0] {FMT_SMALL, FMT_BIG, FMT_LATER, FMT_LATER2} fmt_e;
	// read cycle trigger modes
	typedef enum logic [1:0] {MODE_CONT, MODE_CONT_AUTO, MODE_EXT_EDGE, MODE_SERIAL_EDGE} mode_e;
	// read cycle sequencer
	typedef enum logic [2:0] {ST_IDLE, ST_EXPOSE, ST_DECODE, ST_PUBLISH} rc_state_e;
	// device status word, bit 7 first
	typedef struct packed {
		logic ext_out;
		logic fail;
		logic pass;
		logic in_cycle;
		logic data_ready;
		logic decoding;
		logic expo_done;
		logic trig_ack;
	} status_s;
	// one write into the match store
	typedef struct packed {
		logic we;
		logic [11:0] addr;
		logic [7:0] ch;
	} match_wr_s;
endpackage : rc_pkg

//--- core/match_store.sv
`timescale 1ns/1ps
`include "rc_params.svh"
module match_store
	import rc_pkg::*;
#(
	parameter int DEPTH = `RC_MATCH_TOTAL
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire match_wr_s wr,
	input wire logic [11:0] rd_addr,
	output logic [7:0] rd_data
);
	// address field is twelve bits wide
	initial begin
		if (DEPTH < 1 || DEPTH > 4096) begin
			$error("match_store depth out of range");
		end
	end

	// character cells, flops addressed by index; no reset, contents are data
	logic [7:0] mem_q [DEPTH];

	////////////////////////////////////////////////////////////////////////////
	// write port
	always_ff @(posedge core_clk) begin
		if (wr.we && int'(wr.addr) < DEPTH) begin
			mem_q[wr.addr] <= wr.ch;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registered read port; out of range reads zero
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rd_data <= 8'h00;
		end else if (int'(rd_addr) < DEPTH) begin
			rd_data <= mem_q[rd_addr];
		end else begin
			rd_data <= 8'h00;
		end
	end
endmodule : match_store

//--- core/read_cycle_status.sv
`timescale 1ns/1ps
`include "rc_params.svh"
module read_cycle_status
	import rc_pkg::*;
#(
	parameter int MATCH_TOTAL = `RC_MATCH_TOTAL,
	parameter int MAX_ENTRIES = 15
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic trigger_in,
	input wire logic expo_end_in,
	input wire logic decode_done_in,
	input wire logic decode_ok_in,
	input wire logic [31:0] decode_data_in,
	output status_s status_o,
	output logic autofocus_en_o,
	output logic irq_o
);
	// the store address is twelve bits and the index field four
	initial begin
		if (MATCH_TOTAL < 1 || MATCH_TOTAL > 4095 || MAX_ENTRIES < 1 || MAX_ENTRIES > 15) begin
			$error("read_cycle_status parameters out of range");
		end
	end

	// per-entry capacity; shared by write check and address math
	function automatic logic [11:0] entry_cap(input logic [3:0] n);
		entry_cap = (n == 4'h0) ? 12'h000 : 12'(MATCH_TOTAL / int'(n));
	endfunction : entry_cap

	// cell address of an entry (one-based index) and character offset
	function automatic logic [11:0] cell_addr(input logic [3:0] idx, input logic [3:0] n,
		input logic [11:0] ofs);
		cell_addr = 12'((32'(idx) - 32'h1) * 32'(entry_cap(n)) + 32'(ofs));
	endfunction : cell_addr

	////////////////////////////////////////////////////////////////////////////
	// bus front end
	logic bus_req; // request present and not yet answered
	logic wr_hit; // write taken this edge
	logic [5:0] ctrl_q; // format, mode, autofocus request, output condition
	logic [3:0] irq_stat_q; // sticky events
	logic [3:0] irq_en_q; // event enables
	logic [3:0] match_cnt_q; // registered entry count
	logic [11:0] rd_ptr_q; // match store read pointer
	logic cmd_err_q; // last match command refused
	logic [31:0] data_q; // stored decode data
	status_s st_q; // status word
	rc_state_e state_q; // sequencer state
	logic trig_prev_q; // trigger level one cycle ago
	logic [7:0] rd_char; // match store read data
	match_wr_s mwr; // match store write
	fmt_e fmt;
	mode_e mode;

	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_hit = bus_req && wb_we_i;
	assign fmt = fmt_e'(ctrl_q[`RC_CTRL_FMT_LSB +: 2]);
	assign mode = mode_e'(ctrl_q[`RC_CTRL_MODE_LSB +: 2]);

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	// read mux, registered with the ack; unmapped reads as zero
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_req && !wb_we_i) begin
			case (wb_adr_i)
				`RC_REG_CTRL: wb_dat_o <= {26'h0, ctrl_q};
				`RC_REG_STATUS: wb_dat_o <= {24'h0, st_q};
				`RC_REG_DATA: wb_dat_o <= data_q;
				`RC_REG_IRQ_STAT: wb_dat_o <= {28'h0, irq_stat_q};
				`RC_REG_IRQ_EN: wb_dat_o <= {28'h0, irq_en_q};
				`RC_REG_MATCH_CNT: wb_dat_o <= {28'h0, match_cnt_q};
				// pointer read: error flag and the character under the pointer
				`RC_REG_MATCH_CMD: wb_dat_o <= {cmd_err_q, 3'h0, 8'h0, 12'(rd_ptr_q), rd_char};
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// control register, low byte lane only
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= `RC_CTRL_RESET;
		end else if (wr_hit && wb_adr_i == `RC_REG_CTRL && wb_sel_i[0]) begin
			ctrl_q <= wb_dat_i[5:0];
		end
	end

	// interrupt enables
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			irq_en_q <= 4'h0;
		end else if (wr_hit && wb_adr_i == `RC_REG_IRQ_EN && wb_sel_i[0]) begin
			irq_en_q <= wb_dat_i[3:0];
		end
	end

	// entry count; zero or too many refused so capacity stays defined
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			match_cnt_q <= `RC_MATCH_CNT_RESET;
		end else if (wr_hit && wb_adr_i == `RC_REG_MATCH_CNT && wb_sel_i[0]
			&& wb_dat_i[3:0] != 4'h0 && int'(wb_dat_i[3:0]) <= MAX_ENTRIES) begin
			match_cnt_q <= wb_dat_i[3:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// match string command decode
	logic mcmd_hit; // full-word write to the command register
	logic [7:0] mcmd_code;
	logic [3:0] mcmd_idx;
	logic [11:0] mcmd_ofs;
	logic mcmd_ok; // index and offset fit the split store
	assign mcmd_hit = wr_hit && wb_adr_i == `RC_REG_MATCH_CMD && wb_sel_i == 4'hF;
	assign mcmd_code = wb_dat_i[`RC_MCMD_CODE_LSB +: 8];
	assign mcmd_idx = wb_dat_i[`RC_MCMD_IDX_LSB +: 4];
	assign mcmd_ofs = wb_dat_i[`RC_MCMD_OFS_LSB +: 12];
	// each entry gets an even share of the store
	assign mcmd_ok = mcmd_idx != 4'h0 && mcmd_idx <= match_cnt_q
		&& mcmd_ofs < entry_cap(match_cnt_q);

	// a write command with a valid slot lands one character there
	always_comb begin
		mwr.we = mcmd_hit && mcmd_code == `RC_MCMD_CODE_WRITE && mcmd_ok;
		mwr.addr = cell_addr(mcmd_idx, match_cnt_q, mcmd_ofs);
		mwr.ch = wb_dat_i[`RC_MCMD_CHAR_LSB +: 8];
	end

	// pointer command moves the read-back pointer; bad slots flag an error
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rd_ptr_q <= 12'h000;
			cmd_err_q <= 1'b0;
		end else if (mcmd_hit) begin
			cmd_err_q <= !mcmd_ok
				|| (mcmd_code != `RC_MCMD_CODE_WRITE && mcmd_code != `RC_MCMD_CODE_POINT);
			if (mcmd_code == `RC_MCMD_CODE_POINT && mcmd_ok) begin
				rd_ptr_q <= cell_addr(mcmd_idx, match_cnt_q, mcmd_ofs);
			end
		end
	end

	match_store #(
		.DEPTH(MATCH_TOTAL)
	) u_store (
		.core_clk(core_clk),
		.nrst(nrst),
		.wr(mwr),
		.rd_addr(rd_ptr_q),
		.rd_data(rd_char)
	);

	////////////////////////////////////////////////////////////////////////////
	// read cycle sequencer
	logic ext_mode; // edge-driven modes use the trigger pin
	logic trig_rise; // trigger went active
	logic trig_fall; // trigger went inactive
	logic read_start; // a new read cycle begins this edge
	assign ext_mode = mode == MODE_EXT_EDGE || mode == MODE_SERIAL_EDGE;
	assign trig_rise = trigger_in && !trig_prev_q;
	assign trig_fall = !trigger_in && trig_prev_q;
	// continuous modes restart by themselves once idle
	assign read_start = state_q == ST_IDLE && (ext_mode ? trig_rise : 1'b1);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			trig_prev_q <= 1'b0;
		end else begin
			trig_prev_q <= trigger_in;
		end
	end

	// state walk: expose, decode, publish, back to idle
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: if (read_start) begin
					state_q <= ST_EXPOSE;
				end
				ST_EXPOSE: if (expo_end_in) begin
					state_q <= ST_DECODE;
				end
				ST_DECODE: if (decode_done_in) begin
					state_q <= ST_PUBLISH;
				end
				ST_PUBLISH: state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// trigger acknowledge mirrors detected edges in edge modes only
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_q.trig_ack <= 1'b0;
		end else if (!ext_mode) begin
			st_q.trig_ack <= 1'b0;
		end else if (trig_rise) begin
			st_q.trig_ack <= 1'b1;
		end else if (trig_fall) begin
			st_q.trig_ack <= 1'b0;
		end
	end

	// exposure flag low from start until the sensor reports the end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_q.expo_done <= 1'b0;
		end else if (read_start) begin
			st_q.expo_done <= 1'b0;
		end else if (state_q == ST_EXPOSE && expo_end_in) begin
			st_q.expo_done <= 1'b1;
		end
	end

	// decoding spans exposure and decode; result lands with data ready
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_q.decoding <= 1'b0;
			st_q.data_ready <= 1'b0;
			st_q.pass <= 1'b0;
			st_q.fail <= 1'b0;
			data_q <= 32'h0000_0000;
		end else if (read_start) begin
			st_q.decoding <= 1'b1;
			st_q.data_ready <= 1'b0;
			st_q.pass <= 1'b0;
			st_q.fail <= 1'b0;
		end else if (state_q == ST_DECODE && decode_done_in) begin
			// one update carries data, verdict and the ready flag
			st_q.decoding <= 1'b0;
			st_q.data_ready <= 1'b1;
			st_q.pass <= decode_ok_in;
			st_q.fail <= !decode_ok_in;
			data_q <= decode_data_in;
		end
	end

	// in-cycle falls one edge after the data is stored, never with it
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_q.in_cycle <= 1'b0;
		end else if (read_start) begin
			st_q.in_cycle <= 1'b1;
		end else if (state_q == ST_PUBLISH) begin
			st_q.in_cycle <= 1'b0;
		end
	end

	// external output only reported in the big layout; default asserts on fail
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_q.ext_out <= 1'b0;
		end else if (fmt != FMT_BIG) begin
			st_q.ext_out <= 1'b0;
		end else begin
			st_q.ext_out <= ctrl_q[`RC_CTRL_COND_BIT] ? st_q.pass : st_q.fail;
		end
	end

	// autofocus allowed only while reading in a continuous mode
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			autofocus_en_o <= 1'b0;
		end else begin
			autofocus_en_o <= ctrl_q[`RC_CTRL_AF_BIT] && !ext_mode && state_q != ST_IDLE;
		end
	end

	assign status_o = st_q;

	////////////////////////////////////////////////////////////////////////////
	// interrupts: sticky events, set beats a same-cycle clear
	logic [3:0] ev; // event pulses
	logic [3:0] clr; // clear mask from software
	assign ev[`RC_EV_START] = read_start;
	assign ev[`RC_EV_READY] = state_q == ST_DECODE && decode_done_in;
	assign ev[`RC_EV_FAIL] = state_q == ST_DECODE && decode_done_in && !decode_ok_in;
	assign ev[`RC_EV_CMDERR] = mcmd_hit && !mcmd_ok;
	assign clr = (wr_hit && wb_adr_i == `RC_REG_IRQ_CLR && wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			irq_stat_q <= 4'h0;
			irq_o <= 1'b0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~clr) | ev;
			irq_o <= |(((irq_stat_q & ~clr) | ev) & irq_en_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_done_ok;
		state_q == ST_DECODE && decode_done_in;
	endsequence
	sequence s_publish;
		st_q.data_ready && !st_q.decoding ##1 !st_q.in_cycle;
	endsequence

	property p_ack_follow;
		@(posedge core_clk) disable iff (!nrst) $rose(trigger_in) && ext_mode |=> st_q.trig_ack;
	endproperty
	a_ack_follow: assert property (p_ack_follow) else $error("trigger ack missed");
	property p_expo;
		@(posedge core_clk) disable iff (!nrst)
			state_q == ST_EXPOSE && !expo_end_in |=> !st_q.expo_done;
	endproperty
	a_expo: assert property (p_expo) else $error("exposure done early");
	property p_decoding;
		@(posedge core_clk) disable iff (!nrst)
			(state_q == ST_EXPOSE || state_q == ST_DECODE) |-> st_q.decoding;
	endproperty
	a_decoding: assert property (p_decoding) else $error("decoding low in cycle");
	property p_publish;
		@(posedge core_clk) disable iff (!nrst) s_done_ok |=> s_publish;
	endproperty
	a_publish: assert property (p_publish) else $error("publish order wrong");
	property p_verdict_quiet;
		@(posedge core_clk) disable iff (!nrst) !st_q.data_ready |-> !st_q.pass && !st_q.fail;
	endproperty
	a_verdict_quiet: assert property (p_verdict_quiet) else $error("verdict early");
	property p_fail_hold;
		@(posedge core_clk) disable iff (!nrst) st_q.fail && !read_start |=> st_q.fail;
	endproperty
	a_fail_hold: assert property (p_fail_hold) else $error("fail dropped");
	property p_af;
		@(posedge core_clk) disable iff (!nrst) autofocus_en_o |-> $past(!ext_mode);
	endproperty
	a_af: assert property (p_af) else $error("autofocus in edge mode");
	property p_ext_start;
		@(posedge core_clk) disable iff (!nrst)
			ext_mode && state_q == ST_IDLE && !trig_rise |=> state_q == ST_IDLE;
	endproperty
	a_ext_start: assert property (p_ext_start) else $error("start without trigger");
	property p_excl;
		@(posedge core_clk) disable iff (!nrst) !(st_q.pass && st_q.fail);
	endproperty
	a_excl: assert property (p_excl) else $error("pass and fail together");
endmodule : read_cycle_status

//--- verif/sensor_model.sv
`timescale 1ns/1ps
// imaging front end: answers each started read with one exposure pulse, then one decode pulse
module sensor_model
	import rc_pkg::*;
#(
	parameter logic [31:0] no_read_marker = 32'h0BAD0BAD // arbitrary filler value
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire status_s status_o,
	input wire logic [4:0] expo_dly,
	input wire logic [4:0] dec_dly,
	input wire logic ok_v,
	input wire logic [31:0] data_v,
	output logic expo_end_in,
	output logic decode_done_in,
	output logic decode_ok_in,
	output logic [31:0] decode_data_in
);
	logic [1:0] phase_q; // 0 wait start, 1 expose, 2 decode, 3 wait end
	logic [4:0] cnt_q; // cycles left in phase
	////////////////////////////////////////////////////////////////
	// sequencing: exposure end always comes before decode end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			phase_q <= 2'h0;
			cnt_q <= 5'h00;
			expo_end_in <= 1'b0;
			decode_done_in <= 1'b0;
		end else begin
			expo_end_in <= 1'b0;
			decode_done_in <= 1'b0;
			case (phase_q)
				2'h0: if (status_o.decoding && !status_o.expo_done) begin
					phase_q <= 2'h1;
					cnt_q <= expo_dly;
				end
				2'h1: if (cnt_q == 5'h00) begin
					expo_end_in <= 1'b1;
					phase_q <= 2'h2;
					cnt_q <= dec_dly;
				end else begin
					cnt_q <= cnt_q - 5'h01;
				end
				2'h2: if (cnt_q == 5'h00) begin
					decode_done_in <= 1'b1;
					phase_q <= 2'h3;
				end else begin
					cnt_q <= cnt_q - 5'h01;
				end
				default: if (!status_o.decoding) begin
					phase_q <= 2'h0;
				end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////
	// result lines mean something only with the pulse; scrambled otherwise
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			decode_ok_in <= 1'b0;
			decode_data_in <= 32'h00000000;
		end else if (phase_q == 2'h2 && cnt_q == 5'h00) begin
			decode_ok_in <= ok_v;
			decode_data_in <= ok_v ? data_v : no_read_marker;
		end else begin
			decode_ok_in <= ~decode_ok_in;
			decode_data_in <= ~decode_data_in;
		end
	end
endmodule : sensor_model

//--- verif/test_read_cycle_status.sv
`timescale 1ns/1ps
`include "rc_params.svh"
module test_read_cycle_status
	import rc_pkg::*;
;
	localparam logic [31:0] no_read_marker = 32'h0BAD0BAD; // arbitrary filler value
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF; // full words only
	logic [31:0] wb_dat_i = 32'h00000000;
	logic trigger_in = 1'b0;
	logic [4:0] expo_dly = 5'h01;
	logic [4:0] dec_dly = 5'h01;
	logic ok_v = 1'b0;
	logic [31:0] data_v = 32'h00000000;
	logic [31:0] wb_dat_o, decode_data_in, rd;
	logic wb_ack_o, autofocus_en_o, irq_o, expo_end_in, decode_done_in, decode_ok_in;
	status_s status_o;
	int err_total = 0;
	int tests_run = 0;
	int mcnt = 1; // entries the store is split into
	always #2.5 core_clk = ~core_clk;
	read_cycle_status dut (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trigger_in(trigger_in),
		.expo_end_in(expo_end_in), .decode_done_in(decode_done_in), .decode_ok_in(decode_ok_in),
		.decode_data_in(decode_data_in), .status_o(status_o), .autofocus_en_o(autofocus_en_o),
		.irq_o(irq_o));
	sensor_model #(.no_read_marker(no_read_marker)) sensor (.core_clk(core_clk), .nrst(nrst),
		.status_o(status_o), .expo_dly(expo_dly), .dec_dly(dec_dly), .ok_v(ok_v),
		.data_v(data_v), .expo_end_in(expo_end_in), .decode_done_in(decode_done_in),
		.decode_ok_in(decode_ok_in), .decode_data_in(decode_data_in));
	////////////////////////////////////////////////////////////////
	// verdict, reached from the main sequence or the watchdog
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish
	// single flag compare
	task automatic chk_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_bit
	// register word compare
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_word
	// classic cycle; request held until the rising edge that sees ack, data taken there
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		@(posedge core_clk);
		// values read here are those settled before this edge
		while (wb_ack_o !== 1'b1 && n < 50) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 50) begin
			err_total++;
		end
		rd = wb_dat_o;
		// released at the ack edge; the next call waits one more edge before rising
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb
	// bounded wait for one status bit
	task automatic wait_st(input int k, input logic v);
		int n;
		n = 0;
		while (status_o[k] !== v && n < 100) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 100) begin
			err_total++;
		end
	endtask : wait_st
	task automatic do_reset();
		nrst <= 1'b0;
		repeat (5) @(posedge core_clk);
		@(negedge core_clk);
		chk_word({24'h000000, status_o}, 32'h00000000);
		@(posedge core_clk);
		nrst <= 1'b1;
	endtask : do_reset
	function automatic logic exp_ext(input logic [1:0] fmt, input logic cond, input logic ok);
		return (fmt == FMT_BIG) && (cond ? ok : !ok);
	endfunction : exp_ext
	function automatic logic exp_err(input int idx, input int ofs);
		return !(idx >= 1 && idx <= mcnt && ofs < `RC_MATCH_TOTAL / mcnt);
	endfunction : exp_err
	// match command, then its error bit
	task automatic mcmd(input logic [7:0] code, input int idx, input int ofs, input logic [7:0] ch);
		wb(1'b1, `RC_REG_MATCH_CMD, {code, 4'(idx), 12'(ofs), ch});
		wb(1'b0, `RC_REG_MATCH_CMD, 32'h00000000);
		chk_bit(rd[31], exp_err(idx, ofs));
	endtask : mcmd
	// one triggered read cycle with a random result and random partner speed
	task automatic run_cycle(input logic [1:0] fmt, input logic cond, input logic ok);
		logic [31:0] d;
		d = $urandom;
		@(posedge core_clk);
		ok_v <= ok;
		data_v <= d;
		expo_dly <= 5'($urandom_range(0, 20));
		dec_dly <= 5'($urandom_range(1, 20));
		trigger_in <= 1'b1;
		@(posedge core_clk);
		@(negedge core_clk);
		chk_bit(status_o.trig_ack, 1'b1);
		chk_bit(status_o.decoding, 1'b1);
		chk_bit(status_o.expo_done, 1'b0);
		chk_bit(status_o.data_ready, 1'b0);
		chk_bit(status_o.pass | status_o.fail, 1'b0);
		chk_bit(autofocus_en_o, 1'b0);
		wait_st(1, 1'b1);
		chk_bit(status_o.decoding, 1'b1);
		wait_st(3, 1'b1);
		chk_bit(status_o.pass, ok);
		chk_bit(status_o.fail, !ok);
		chk_bit(status_o.decoding, 1'b0);
		chk_bit(status_o.in_cycle, 1'b1);
		@(negedge core_clk);
		chk_bit(status_o.in_cycle, 1'b0);
		chk_bit(status_o.ext_out, exp_ext(fmt, cond, ok));
		wb(1'b0, `RC_REG_DATA, 32'h00000000);
		chk_word(rd, ok ? d : no_read_marker);
		wb(1'b0, `RC_REG_STATUS, 32'h00000000);
		chk_bit(rd[3], 1'b1);
		trigger_in <= 1'b0;
		@(posedge core_clk);
		@(negedge core_clk);
		chk_bit(status_o.trig_ack, 1'b0);
		chk_bit(status_o.fail, !ok);
	endtask : run_cycle
	////////////////////////////////////////////////////////////////
	// watchdog, far beyond the thousand or so cycles the run needs
	initial begin
		#100000;
		err_total++;
		tally_and_finish();
	end
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		logic [7:0] c;
		void'($urandom(18248));
		do_reset();
		wb(1'b0, `RC_REG_CTRL, 32'h00000000);
		chk_word(rd, 32'(`RC_CTRL_RESET));
		wb(1'b0, `RC_REG_MATCH_CNT, 32'h00000000);
		chk_word(rd, 32'(`RC_MATCH_CNT_RESET));
		wb(1'b0, 8'h40, 32'h00000000);
		chk_word(rd, 32'h00000000);
		$display("test reset done");
		// continuous modes with autofocus requested
		for (int m = 0; m < 2; m++) begin
			wb(1'b1, `RC_REG_CTRL, {26'h0000000, 2'h1, 2'(m), 2'h0});
			wait_st(4, 1'b0);
			wait_st(4, 1'b1);
			@(negedge core_clk);
			chk_bit(autofocus_en_o, 1'b1);
		end
		$display("test autofocus done");
		// both edge modes, every format, both output conditions
		for (int i = 0; i < 16; i++) begin
			wb(1'b1, `RC_REG_CTRL, {26'h0000000, i[3], 2'h3, i[2], 2'(i % 4)});
			wait_st(4, 1'b0);
			repeat (4) @(negedge core_clk);
			chk_bit(status_o.in_cycle, 1'b0);
			run_cycle(2'(i % 4), i[3], i < 2 ? i[0] : 1'($urandom));
		end
		$display("test read cycles done");
		wb(1'b1, `RC_REG_IRQ_CLR, 32'h0000000F);
		wb(1'b1, `RC_REG_IRQ_EN, 32'h00000002);
		chk_bit(irq_o, 1'b0);
		run_cycle(2'h2, 1'b0, 1'b0);
		wb(1'b0, `RC_REG_IRQ_STAT, 32'h00000000);
		chk_word(rd, 32'h00000007);
		chk_bit(irq_o, 1'b1);
		wb(1'b1, `RC_REG_IRQ_EN, 32'h00000008);
		wb(1'b0, `RC_REG_IRQ_STAT, 32'h00000000);
		chk_bit(irq_o, 1'b0);
		wb(1'b1, `RC_REG_IRQ_EN, 32'h00000002);
		wb(1'b1, `RC_REG_IRQ_CLR, 32'h00000002);
		wb(1'b0, `RC_REG_IRQ_STAT, 32'h00000000);
		chk_word(rd, 32'h00000005);
		chk_bit(irq_o, 1'b0);
		$display("test interrupt done");
		// match store split, command writes and pointer readback
		mcmd(`RC_MCMD_CODE_WRITE, 1, 2999, 8'h5A);
		wb(1'b1, `RC_REG_MATCH_CNT, 32'h00000000);
		wb(1'b0, `RC_REG_MATCH_CNT, 32'h00000000);
		chk_word(rd, 32'h00000001);
		mcnt = 10;
		wb(1'b1, `RC_REG_MATCH_CNT, 32'h0000000A);
		wb(1'b0, `RC_REG_MATCH_CNT, 32'h00000000);
		chk_word(rd, 32'h0000000A);
		c = 8'($urandom);
		mcmd(`RC_MCMD_CODE_WRITE, 1, 299, c);
		mcmd(`RC_MCMD_CODE_WRITE, 10, 0, ~c);
		mcmd(`RC_MCMD_CODE_POINT, 1, 299, 8'h00);
		wb(1'b0, `RC_REG_MATCH_CMD, 32'h00000000);
		chk_word({24'h000000, rd[7:0]}, {24'h000000, c});
		mcmd(`RC_MCMD_CODE_POINT, 10, 0, 8'h00);
		wb(1'b0, `RC_REG_MATCH_CMD, 32'h00000000);
		chk_word({24'h000000, rd[7:0]}, {24'h000000, ~c});
		mcmd(`RC_MCMD_CODE_WRITE, 1, 300, c);
		mcmd(`RC_MCMD_CODE_WRITE, 11, 0, c);
		mcmd(`RC_MCMD_CODE_WRITE, 0, 5, c);
		wb(1'b0, `RC_REG_IRQ_STAT, 32'h00000000);
		chk_bit(rd[3], 1'b1);
		$display("test match store done");
		do_reset();
		wb(1'b0, `RC_REG_CTRL, 32'h00000000);
		chk_word(rd, 32'(`RC_CTRL_RESET));
		$display("test second reset done");
		tally_and_finish();
	end
endmodule : test_read_cycle_status
